// ### pems_regs.svh
`ifndef PEMS_REGS_SVH
`define PEMS_REGS_SVH

// ============================================================
// register numbers
`define PEMS_ADDR_MASK0 6'h01
`define PEMS_ADDR_SENSE0 6'h02
`define PEMS_ADDR_FLAGS1 6'h03
`define PEMS_ADDR_MASK1 6'h04

// ============================================================
// implemented bits of each word
`define PEMS_MASK0_IMPL 24'h397FFF
`define PEMS_SENSE0_IMPL 24'h197FF8
`define PEMS_WORD1_IMPL 24'hC1FFFF

// ============================================================
// reset domain membership
`define PEMS_MASK0_PIN_BITS 24'h386F17
`define PEMS_MASK0_RTC_BITS 24'h0000A0
`define PEMS_MASK0_OFF_BITS 24'h011048
`define PEMS_WORD1_PIN_BITS 24'hC1F000
`define PEMS_WORD1_RTC_BITS 24'h000EE3
`define PEMS_WORD1_OFF_BITS 24'h00011C

// ============================================================
// reset values; unimplemented mask bits read one
`define PEMS_MASK0_DEFAULT 24'hFFFFFF
`define PEMS_FLAGS1_DEFAULT 24'h000080
`define PEMS_MASK1_DEFAULT 24'hFFF7FF

// ============================================================
// field positions
`define PEMS_BIT_WDOG_RESET 5
`define PEMS_BIT_BUTTON_RESET 6
`define PEMS_BIT_CHG_ON 7
`define PEMS_BIT_LP_BOOT 11
`define PEMS_BIT_THERM_LOW 12
`define PEMS_BIT_THERM_HIGH 13
`define PEMS_BIT_SHORT_TRIP 16
`define PEMS_BIT_SESSION_VALID 16
`define PEMS_BIT_WALL_CHG 21
`define PEMS_BIT_BATT_REMOVAL 22

// ============================================================
// synchroniser
`define PEMS_SYNC_STAGES 2

`endif

// ### pems_pkg.sv
package pems_pkg;
	typedef logic [23:0] pems_word_t;
	typedef logic [5:0] pems_addr_t;
endpackage

// ### pems_sync.sv
`timescale 1ns/1ps
// ============================================================
// two-stage synchroniser, reset to a fixed constant
module pems_sync #(
	parameter int WIDTH = 1,
	parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// data
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			meta_reg <= RESET_VAL;
			sync_reg <= RESET_VAL;
		end else begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule // pems_sync

// ### pems_top.sv
`timescale 1ns/1ps
`include "pems_regs.svh"
// Operation
// - short trip sets flag bit 16; write-one clears; reset pin clears.
// - implemented mask bits reset to one except mask bit 11, e.g. battery removal bit 22.
// - low-power boot mask bit 11 resets to zero, only by clock power-on.
// - thermal low and high flags at bits 12, 13, cleared by reset pin.
// - watchdog reset sets bit 5; survives reset pin.
// - button reset sets bit 6; only clock power-on or write-one clears.
// - low-power boot sets bit 11; survives reset pin.
// - charger-on sense is read-only bit 7, zero by default.
// - session valid sense is live read-only bit 16, zero by default.
// - wall charger mask bit 21 is read-write, one after reset pin.
// - writing one clears a flag, zero leaves it, reads show it.
// - sense bits follow their inputs without latching.
// - pin bits held while pin low; clock bits released on power good.
// - off-state bits return to default on entering the off state.
module pems_top (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// reset sources
	input wire logic reset_pin_low_n,
	input wire logic rtc_poweron_reset_n,
	input wire logic off_state_reset,
	// register access
	input wire pems_pkg::pems_addr_t reg_addr,
	input wire logic reg_wr,
	input wire logic reg_rd,
	input wire pems_pkg::pems_word_t reg_wdata,
	output pems_pkg::pems_word_t reg_rdata,
	output logic reg_rvalid,
	// event sources
	input wire logic short_trip_evt,
	input wire logic thermal_low_evt,
	input wire logic thermal_high_evt,
	input wire logic watchdog_reset_evt,
	input wire logic button_reset_evt,
	input wire logic lowpower_usb_boot_evt,
	input wire logic battery_removal_evt,
	input wire pems_pkg::pems_word_t other_event_in,
	// sense inputs
	input wire logic charger_on_sense,
	input wire logic usb_session_valid_sense,
	input wire pems_pkg::pems_word_t other_sense_in,
	// interrupt request
	output logic irq_pending
);
	// ============================================================
	// input synchronisers
	pems_pkg::pems_word_t evt_raw;
	pems_pkg::pems_word_t evt_sync;
	pems_pkg::pems_word_t sense_raw;
	pems_pkg::pems_word_t sense_sync;
	logic [2:0] rst_raw;
	logic [2:0] rst_sync;
	logic pin_act;
	logic rtc_act;
	logic off_act;

	always_comb begin
		evt_raw = other_event_in;
		evt_raw[`PEMS_BIT_SHORT_TRIP] = short_trip_evt;
		evt_raw[`PEMS_BIT_THERM_LOW] = thermal_low_evt;
		evt_raw[`PEMS_BIT_THERM_HIGH] = thermal_high_evt;
		evt_raw[`PEMS_BIT_WDOG_RESET] = watchdog_reset_evt;
		evt_raw[`PEMS_BIT_BUTTON_RESET] = button_reset_evt;
		evt_raw[`PEMS_BIT_LP_BOOT] = lowpower_usb_boot_evt;
		evt_raw[`PEMS_BIT_BATT_REMOVAL] = battery_removal_evt;
		sense_raw = other_sense_in;
		sense_raw[`PEMS_BIT_CHG_ON] = charger_on_sense;
		sense_raw[`PEMS_BIT_SESSION_VALID] = usb_session_valid_sense;
		rst_raw = {off_state_reset, rtc_poweron_reset_n, reset_pin_low_n};
	end

	pems_sync #(.WIDTH(24), .RESET_VAL(24'h000000)) u_evt_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(evt_raw),
		.sync_out(evt_sync)
	);

	pems_sync #(.WIDTH(24), .RESET_VAL(24'h000000)) u_sense_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(sense_raw),
		.sync_out(sense_sync)
	);

	// reset sources come up asserted
	pems_sync #(.WIDTH(3), .RESET_VAL(3'h4)) u_rst_sync (
		.sys_clk(sys_clk),
		.rst(rst),
		.async_in(rst_raw),
		.sync_out(rst_sync)
	);

	assign pin_act = ~rst_sync[0];
	assign rtc_act = ~rst_sync[1];
	assign off_act = rst_sync[2];

	// ============================================================
	// event edge detect
	pems_pkg::pems_word_t evt_prev_reg;
	pems_pkg::pems_word_t evt_prev_next;
	pems_pkg::pems_word_t set_vec;

	always_comb begin
		evt_prev_next = evt_sync;
		set_vec = evt_sync & ~evt_prev_reg & `PEMS_WORD1_IMPL;
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			evt_prev_reg <= 24'h000000;
		end else begin
			evt_prev_reg <= evt_prev_next;
		end
	end

	// ============================================================
	// flag and mask words
	pems_pkg::pems_word_t flags1_reg;
	pems_pkg::pems_word_t flags1_next;
	pems_pkg::pems_word_t mask0_reg;
	pems_pkg::pems_word_t mask0_next;
	pems_pkg::pems_word_t mask1_reg;
	pems_pkg::pems_word_t mask1_next;
	pems_pkg::pems_word_t w1_hold;
	pems_pkg::pems_word_t m0_hold;
	logic irq_next;
	logic wr_flags1;
	logic wr_mask0;
	logic wr_mask1;

	always_comb begin
		wr_flags1 = reg_wr && (reg_addr == `PEMS_ADDR_FLAGS1);
		wr_mask0 = reg_wr && (reg_addr == `PEMS_ADDR_MASK0);
		wr_mask1 = reg_wr && (reg_addr == `PEMS_ADDR_MASK1);
		// bits forced to default by active reset domains
		w1_hold = (pin_act ? `PEMS_WORD1_PIN_BITS : 24'h000000) |
			(rtc_act ? `PEMS_WORD1_RTC_BITS : 24'h000000) |
			(off_act ? `PEMS_WORD1_OFF_BITS : 24'h000000);
		m0_hold = (pin_act ? `PEMS_MASK0_PIN_BITS : 24'h000000) |
			(rtc_act ? `PEMS_MASK0_RTC_BITS : 24'h000000) |
			(off_act ? `PEMS_MASK0_OFF_BITS : 24'h000000);
		// set wins over a simultaneous write-one clear
		flags1_next = flags1_reg;
		if (wr_flags1) begin
			flags1_next = flags1_reg & ~reg_wdata;
		end
		flags1_next = flags1_next | set_vec;
		flags1_next = (flags1_next & ~w1_hold) |
			(`PEMS_FLAGS1_DEFAULT & w1_hold);
		flags1_next = flags1_next & `PEMS_WORD1_IMPL;
		mask0_next = mask0_reg;
		if (wr_mask0) begin
			mask0_next = reg_wdata;
		end
		mask0_next = (mask0_next & ~m0_hold) |
			(`PEMS_MASK0_DEFAULT & m0_hold);
		mask0_next = mask0_next | ~`PEMS_MASK0_IMPL;
		mask1_next = mask1_reg;
		if (wr_mask1) begin
			mask1_next = reg_wdata;
		end
		mask1_next = (mask1_next & ~w1_hold) |
			(`PEMS_MASK1_DEFAULT & w1_hold);
		mask1_next = mask1_next | ~`PEMS_WORD1_IMPL;
		irq_next = |(flags1_reg & ~mask1_reg);
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			flags1_reg <= `PEMS_FLAGS1_DEFAULT;
			mask0_reg <= `PEMS_MASK0_DEFAULT;
			mask1_reg <= `PEMS_MASK1_DEFAULT;
			irq_pending <= 1'b0;
		end else begin
			flags1_reg <= flags1_next;
			mask0_reg <= mask0_next;
			mask1_reg <= mask1_next;
			irq_pending <= irq_next;
		end
	end

	// ============================================================
	// read port
	pems_pkg::pems_word_t rdata_next;
	logic rvalid_next;

	always_comb begin
		rvalid_next = reg_rd;
		rdata_next = reg_rdata;
		if (reg_rd) begin
			if (reg_addr == `PEMS_ADDR_MASK0) begin
				rdata_next = mask0_reg;
			end else if (reg_addr == `PEMS_ADDR_SENSE0) begin
				rdata_next = sense_sync & `PEMS_SENSE0_IMPL;
			end else if (reg_addr == `PEMS_ADDR_FLAGS1) begin
				rdata_next = flags1_reg;
			end else if (reg_addr == `PEMS_ADDR_MASK1) begin
				rdata_next = mask1_reg;
			end else begin
				rdata_next = 24'h000000;
			end
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 24'h000000;
			reg_rvalid <= 1'b0;
		end else begin
			reg_rdata <= rdata_next;
			reg_rvalid <= rvalid_next;
		end
	end

	// ============================================================
	// assertions
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	a_short_set: assert property (
		set_vec[16] && !pin_act |=> flags1_reg[16])
		else $error("short trip flag not set");
	a_flag_w1c: assert property (
		wr_flags1 && reg_wdata[16] && !set_vec[16] |=> !flags1_reg[16])
		else $error("write one did not clear flag");
	a_mask_pin_reset: assert property (
		pin_act |=> mask1_reg[22] && mask0_reg[21] && mask1_reg[16])
		else $error("mask not one after reset pin");
	a_lpb_mask_keep: assert property (
		pin_act && !rtc_act && !wr_mask1 |=> $stable(mask1_reg[11]))
		else $error("boot mask disturbed by reset pin");
	a_rtc_lpb_mask: assert property (
		rtc_act |=> !mask1_reg[11])
		else $error("boot mask not zero after clock reset");
	a_thermal_clear: assert property (
		pin_act |=> flags1_reg[13:12] == 2'h0)
		else $error("thermal flags survive reset pin");
	a_wdog_keep: assert property (
		flags1_reg[5] && !rtc_act && !wr_flags1 |=> flags1_reg[5])
		else $error("watchdog flag lost");
	a_button_keep: assert property (
		flags1_reg[6] && !rtc_act && !wr_flags1 |=> flags1_reg[6])
		else $error("button reset flag lost");
	a_lpb_keep: assert property (
		flags1_reg[11] && !rtc_act && !wr_flags1 |=> flags1_reg[11])
		else $error("boot flag lost");
	a_chg_sense: assert property (
		reg_rd && reg_addr == `PEMS_ADDR_SENSE0
		|=> reg_rdata[7] == $past(sense_sync[7]))
		else $error("charger sense wrong");
	a_session_live: assert property (
		reg_rd && reg_addr == `PEMS_ADDR_SENSE0
		|=> reg_rdata[16] == $past(sense_sync[16]) && reg_rvalid)
		else $error("session sense wrong");
	a_wall_mask_rw: assert property (
		wr_mask0 && !pin_act |=> mask0_reg[21] == $past(reg_wdata[21]))
		else $error("wall charger mask not written");
	a_sense_follow: assert property (
		reg_rd && reg_addr == `PEMS_ADDR_SENSE0
		|=> reg_rdata == ($past(sense_sync) & `PEMS_SENSE0_IMPL))
		else $error("sense read mismatch");
	a_off_reset: assert property (
		off_act |=> flags1_reg[4:2] == 3'h0 && mask1_reg[8])
		else $error("off-state bits not defaulted");
	a_irq_follow: assert property (
		|(flags1_reg & ~mask1_reg) |=> irq_pending)
		else $error("interrupt not raised");
	a_irq_quiet: assert property (
		!(|(flags1_reg & ~mask1_reg)) |=> !irq_pending)
		else $error("spurious interrupt");
	a_resv_read: assert property (
		reg_rd && reg_addr == `PEMS_ADDR_FLAGS1 |=> reg_rdata[21:17] == 5'h00)
		else $error("reserved flag bits not zero");
	a_resv_mask: assert property (
		mask0_reg[23:22] == 2'h3 && mask1_reg[21:17] == 5'h1F)
		else $error("reserved mask bits not one");
	a_scp_keep: assert property (
		!pin_act && !set_vec[16] && !(wr_flags1 && reg_wdata[16])
		|=> $stable(flags1_reg[16]))
		else $error("short trip flag changed without cause");
	a_wall_mask_keep: assert property (
		!pin_act && !wr_mask0 |=> $stable(mask0_reg[21]))
		else $error("wall charger mask changed without cause");
	a_pin_flags_clr: assert property (
		pin_act |=> (flags1_reg & `PEMS_WORD1_PIN_BITS) == 24'h000000)
		else $error("pin domain flags not held clear");
	a_rtc_flags_clr: assert property (
		rtc_act |=> flags1_reg[6:5] == 2'h0 && !flags1_reg[11])
		else $error("clock domain flags not cleared");

	c_short_irq: cover property (set_vec[16] ##1 flags1_reg[16] ##1 irq_pending);
	c_w1c_clear: cover property (flags1_reg[5] ##1 wr_flags1 ##1 !flags1_reg[5]);
	c_set_vs_clear: cover property (wr_flags1 && reg_wdata[12] && set_vec[12]);
	c_lpb_survive: cover property (flags1_reg[11] && pin_act ##1 flags1_reg[11]);
	c_rtc_restore: cover property (flags1_reg[5] && rtc_act ##1 !flags1_reg[5]);
endmodule // pems_top

// ### pems_host.sv
`timescale 1ns/1ps
// ============================================================
// processor side: issues single register accesses
module pems_host (
	// clock
	input wire logic sys_clk,
	// register port
	output pems_pkg::pems_addr_t reg_addr,
	output logic reg_wr,
	output logic reg_rd,
	output pems_pkg::pems_word_t reg_wdata,
	input wire pems_pkg::pems_word_t reg_rdata,
	input wire logic reg_rvalid
);
	initial begin
		reg_addr = '0;
		reg_wr = 1'b0;
		reg_rd = 1'b0;
		reg_wdata = '0;
	end

	task automatic wr_word(input pems_pkg::pems_addr_t a,
		input pems_pkg::pems_word_t d);
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_wr = 1'b0;
		// released data is scrambled, never left at the last value
		reg_wdata = ~d;
	endtask

	task automatic rd_word(input pems_pkg::pems_addr_t a,
		output pems_pkg::pems_word_t d);
		int n;
		@(posedge sys_clk);
		#1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge sys_clk);
		#1;
		reg_rd = 1'b0;
		n = 0;
		while (reg_rvalid !== 1'b1 && n < 4) begin
			@(posedge sys_clk);
			#1;
			n++;
		end
		d = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
	endtask
endmodule // pems_host

// ### pems_testbench.sv
`timescale 1ns/1ps
`include "pems_regs.svh"
`define PEMS_CHK(got, exp) begin cmp_count++; if ((got) !== (exp)) begin \
	error_cnt++; $display("[ERR] %0t got %h exp %h", $time, got, exp); end end
module testbench;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic pin_n = 1'b1;
	logic rtc_n = 1'b1;
	logic off_rst = 1'b0;
	logic sc = 1'b0, tl = 1'b0, th = 1'b0, wd = 1'b0, bt = 1'b0, lp = 1'b0;
	logic br = 1'b0, chg = 1'b0, ses = 1'b0;
	pems_pkg::pems_word_t oevt = 24'h000000;
	pems_pkg::pems_word_t osen = 24'h000000;
	logic wr, rd, rvalid, irq;
	pems_pkg::pems_addr_t addr;
	pems_pkg::pems_word_t wdata, rdata;
	int error_cnt = 0;
	int cmp_count = 0;

	always #4 sys_clk = ~sys_clk;

	pems_host host_u (.sys_clk(sys_clk), .reg_addr(addr), .reg_wr(wr),
		.reg_rd(rd), .reg_wdata(wdata), .reg_rdata(rdata),
		.reg_rvalid(rvalid));

	pems_top dut_u (.sys_clk(sys_clk), .rst(rst), .reset_pin_low_n(pin_n),
		.rtc_poweron_reset_n(rtc_n), .off_state_reset(off_rst),
		.reg_addr(addr), .reg_wr(wr), .reg_rd(rd), .reg_wdata(wdata),
		.reg_rdata(rdata), .reg_rvalid(rvalid), .short_trip_evt(sc),
		.thermal_low_evt(tl), .thermal_high_evt(th),
		.watchdog_reset_evt(wd), .button_reset_evt(bt),
		.lowpower_usb_boot_evt(lp), .battery_removal_evt(br),
		.other_event_in(oevt), .charger_on_sense(chg),
		.usb_session_valid_sense(ses), .other_sense_in(osen),
		.irq_pending(irq));

	// ============================================================
	// helpers
	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask

	task automatic rd_chk(input pems_pkg::pems_addr_t a,
		input pems_pkg::pems_word_t exp);
		pems_pkg::pems_word_t v;
		host_u.rd_word(a, v);
		`PEMS_CHK(v, exp)
	endtask

	task automatic final_report();
		$display("compares %0d mismatches %0d", cmp_count, error_cnt);
		if (error_cnt == 0 && cmp_count > 0) begin
			$display("bench passed");
		end else begin
			$display("bench failed");
		end
		$finish;
	endtask

	// ============================================================
	// scenarios
	task automatic t_defaults();
		rd_chk(`PEMS_ADDR_MASK0, `PEMS_MASK0_DEFAULT);
		rd_chk(`PEMS_ADDR_MASK1, `PEMS_MASK1_DEFAULT);
		rd_chk(`PEMS_ADDR_FLAGS1, `PEMS_FLAGS1_DEFAULT);
		rd_chk(`PEMS_ADDR_SENSE0, 24'h000000);
		rd_chk(6'h08, 24'h000000);
		$display("test defaults done");
	endtask

	task automatic t_sense();
		chg = 1'b1;
		ses = 1'b1;
		cyc(3);
		rd_chk(`PEMS_ADDR_SENSE0, 24'h010080);
		osen = 24'hFFFFFF;
		cyc(3);
		rd_chk(`PEMS_ADDR_SENSE0, `PEMS_SENSE0_IMPL);
		osen = 24'h000000;
		chg = 1'b0;
		cyc(3);
		rd_chk(`PEMS_ADDR_SENSE0, 24'h010000);
		ses = 1'b0;
		cyc(3);
		rd_chk(`PEMS_ADDR_SENSE0, 24'h000000);
		$display("test sense done");
	endtask

	task automatic t_short();
		host_u.wr_word(`PEMS_ADDR_FLAGS1, 24'h000080);
		host_u.wr_word(`PEMS_ADDR_MASK1, 24'hFEF7FF);
		cyc(2);
		`PEMS_CHK(irq, 1'b0)
		sc = 1'b1;
		cyc(2);
		sc = 1'b0;
		cyc(3);
		`PEMS_CHK(irq, 1'b1)
		rd_chk(`PEMS_ADDR_FLAGS1, 24'h010000);
		host_u.wr_word(`PEMS_ADDR_FLAGS1, 24'h000000);
		rd_chk(`PEMS_ADDR_FLAGS1, 24'h010000);
		host_u.wr_word(`PEMS_ADDR_FLAGS1, 24'h010000);
		rd_chk(`PEMS_ADDR_FLAGS1, 24'h000000);
		cyc(1);
		`PEMS_CHK(irq, 1'b0)
		$display("test short trip done");
	endtask

	task automatic t_pin();
		pems_pkg::pems_word_t v;
		{sc, tl, th, wd, bt, lp, br} = 7'h7F;
		cyc(2);
		{sc, tl, th, wd, bt, lp, br} = 7'h00;
		cyc(3);
		rd_chk(`PEMS_ADDR_FLAGS1, 24'h413860);
		host_u.wr_word(`PEMS_ADDR_MASK0, 24'hDFFFFF);
		host_u.wr_word(`PEMS_ADDR_MASK1, 24'hBFF7FF);
		pin_n = 1'b0;
		cyc(4);
		rd_chk(`PEMS_ADDR_MASK0, `PEMS_MASK0_DEFAULT);
		pin_n = 1'b1;
		cyc(4);
		host_u.rd_word(`PEMS_ADDR_FLAGS1, v);
		`PEMS_CHK(v[16], 1'b0)
		`PEMS_CHK(v[22], 1'b0)
		`PEMS_CHK(v[13:12], 2'b00)
		`PEMS_CHK(v[5], 1'b1)
		`PEMS_CHK(v[6], 1'b1)
		`PEMS_CHK(v[11], 1'b1)
		rd_chk(`PEMS_ADDR_MASK0, `PEMS_MASK0_DEFAULT);
		rd_chk(`PEMS_ADDR_MASK1, `PEMS_MASK1_DEFAULT);
		$display("test pin reset done");
	endtask

	task automatic t_rtc();
		host_u.wr_word(`PEMS_ADDR_MASK1, 24'hFFFFFF);
		rtc_n = 1'b0;
		cyc(4);
		rtc_n = 1'b1;
		cyc(4);
		rd_chk(`PEMS_ADDR_FLAGS1, `PEMS_FLAGS1_DEFAULT);
		rd_chk(`PEMS_ADDR_MASK1, `PEMS_MASK1_DEFAULT);
		$display("test clock power-on done");
	endtask

	task automatic t_reserved_off();
		host_u.wr_word(`PEMS_ADDR_MASK1, 24'h000000);
		rd_chk(`PEMS_ADDR_MASK1, ~`PEMS_WORD1_IMPL);
		host_u.wr_word(`PEMS_ADDR_MASK0, 24'h000000);
		rd_chk(`PEMS_ADDR_MASK0, ~`PEMS_MASK0_IMPL);
		off_rst = 1'b1;
		cyc(2);
		off_rst = 1'b0;
		cyc(4);
		rd_chk(`PEMS_ADDR_MASK1, ~`PEMS_WORD1_IMPL | `PEMS_WORD1_OFF_BITS);
		oevt = 24'hFFFFFF;
		cyc(2);
		oevt = 24'h000000;
		cyc(3);
		rd_chk(`PEMS_ADDR_FLAGS1, 24'h80C79F);
		host_u.wr_word(`PEMS_ADDR_FLAGS1, 24'hFFFFFF);
		rd_chk(`PEMS_ADDR_FLAGS1, 24'h000000);
		$display("test reserved and off-state done");
	endtask

	// ============================================================
	// main sequence and watchdog
	initial begin
		repeat (12) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		cyc(4);
		t_defaults();
		t_sense();
		t_short();
		t_pin();
		t_rtc();
		t_reserved_off();
		final_report();
	end

	initial begin
		#200000;
		error_cnt++;
		final_report();
	end
endmodule // testbench
